// ===== verilog/tcc_pkg.sv
// Shared constants and carrier types of the 8-bit timer compare unit.
package tcc_pkg;

	// ****************************************
	// Counter values
	// ****************************************
	localparam logic [7:0] TCC_MAX = 8'hff;
	localparam logic [7:0] TCC_BOTTOM = 8'h00;
	localparam logic [7:0] TCC_ONE = 8'h01;
	localparam logic [7:0] TCC_COUNT_RST = 8'h00;
	localparam logic [7:0] TCC_CMP_RST = 8'h00;
	localparam logic TCC_OC_RST = 1'b0;

	// ****************************************
	// Waveform modes
	// ****************************************
	localparam logic [1:0] TCC_WGM_NORMAL = 2'h0;
	localparam logic [1:0] TCC_WGM_PCPWM = 2'h1;
	localparam logic [1:0] TCC_WGM_CLR_MATCH = 2'h2;
	localparam logic [1:0] TCC_WGM_FAST = 2'h3;

	// ****************************************
	// Output actions
	// ****************************************
	localparam logic [1:0] TCC_ACT_NONE = 2'h0;
	localparam logic [1:0] TCC_ACT_TOGGLE = 2'h1;
	localparam logic [1:0] TCC_ACT_CLEAR = 2'h2;
	localparam logic [1:0] TCC_ACT_SET = 2'h3;

	// ****************************************
	// Clock sources and prescaler masks
	// ****************************************
	localparam logic [2:0] TCC_CS_STOP = 3'h0;
	localparam logic [2:0] TCC_CS_DIV1 = 3'h1;
	localparam logic [2:0] TCC_CS_DIV8 = 3'h2;
	localparam logic [2:0] TCC_CS_DIV64 = 3'h3;
	localparam logic [2:0] TCC_CS_DIV256 = 3'h4;
	localparam logic [2:0] TCC_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TCC_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] TCC_CS_EXT_RISE = 3'h7;
	localparam logic [9:0] TCC_MASK8 = 10'h007;
	localparam logic [9:0] TCC_MASK64 = 10'h03f;
	localparam logic [9:0] TCC_MASK256 = 10'h0ff;
	localparam logic [9:0] TCC_MASK1024 = 10'h3ff;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed
	{
		logic [2:0] clock_source_select;
		logic [1:0] waveform_mode_select;
		logic [1:0] output_action_select;
	} tcc_ctrl_t;

	typedef struct packed
	{
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic global_irq_enable;
	} tcc_irq_en_t;

endpackage

// ===== verilog/tcc_tick_gen.sv
// Timer tick generator: prescaler and external event edge detector.
module tcc_tick_gen
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Source selection and external event level.
	input wire logic [2:0] clock_source_select,
	input wire logic ext_event,
	// One-cycle timer tick enable.
	output logic timer_tick
);
	import tcc_pkg::*;

	logic [9:0] presc_q;
	logic ext_q;
	logic tick_d;

	// Free-running prescaler.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			presc_q <= '0;
		else
			presc_q <= presc_q + 10'h001;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ext_q <= 1'b0;
		else
			ext_q <= ext_event;
	end

	always_comb
	begin
		unique case (clock_source_select)
			TCC_CS_STOP: tick_d = 1'b0;
			TCC_CS_DIV1: tick_d = 1'b1;
			TCC_CS_DIV8: tick_d = (presc_q & TCC_MASK8) == TCC_MASK8;
			TCC_CS_DIV64: tick_d = (presc_q & TCC_MASK64) == TCC_MASK64;
			TCC_CS_DIV256: tick_d = (presc_q & TCC_MASK256) == TCC_MASK256;
			TCC_CS_DIV1024: tick_d = presc_q == TCC_MASK1024;
			TCC_CS_EXT_FALL: tick_d = ext_q & ~ext_event;
			TCC_CS_EXT_RISE: tick_d = ~ext_q & ext_event;
		endcase
	end

	// A stopped source gives no tick from the next edge on.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			timer_tick <= 1'b0;
		else
			timer_tick <= tick_d;
	end

endmodule

// ===== verilog/tcc_out_unit.sv
// Compare output register and port pin override.
module tcc_out_unit
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Mode, action and events.
	input wire logic [1:0] waveform_mode_select,
	input wire logic [1:0] output_action_select,
	input wire logic match_ev,
	input wire logic force_ev,
	input wire logic bottom_ev,
	input wire logic count_up,
	// Port pin.
	input wire logic port_data,
	input wire logic pin_direction_bit,
	output logic compare_output,
	output logic pin_out,
	output logic pin_oe_n
);
	import tcc_pkg::*;

	logic oc_d;
	logic nonpwm_d;

	always_comb
	begin
		unique case (output_action_select)
			TCC_ACT_NONE: nonpwm_d = compare_output;
			TCC_ACT_TOGGLE: nonpwm_d = ~compare_output;
			TCC_ACT_CLEAR: nonpwm_d = 1'b0;
			TCC_ACT_SET: nonpwm_d = 1'b1;
		endcase
	end

	// The action in force at the event is used, so a new action acts at once.
	always_comb
	begin
		oc_d = compare_output;
		if (force_ev)
			oc_d = nonpwm_d;
		else if (match_ev && output_action_select != TCC_ACT_NONE)
		begin
			unique case (waveform_mode_select)
				TCC_WGM_NORMAL, TCC_WGM_CLR_MATCH: oc_d = nonpwm_d;
				TCC_WGM_FAST: oc_d = nonpwm_d;
				TCC_WGM_PCPWM:
					if (output_action_select != TCC_ACT_TOGGLE)
						oc_d = output_action_select[0] ? count_up : ~count_up;
			endcase
		end
		else if (bottom_ev && waveform_mode_select == TCC_WGM_FAST)
		begin
			if (output_action_select[1])
				oc_d = ~output_action_select[0];
		end
	end

	// Reset clears it; a mode change alone never touches it.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			compare_output <= TCC_OC_RST;
		else
			compare_output <= oc_d;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
		end
		else
		begin
			pin_out <= (output_action_select != TCC_ACT_NONE) ? oc_d : port_data;
			pin_oe_n <= ~pin_direction_bit;
		end
	end

	property p_hold_oc;
		@(posedge clk) disable iff (reset)
		(!match_ev && !force_ev && !bottom_ev) |=> $stable(compare_output);
	endproperty
	a_hold_oc: assert property (p_hold_oc) else $error("Output changed without event.");

	property p_pin_src;
		@(posedge clk) disable iff (reset)
		(output_action_select != TCC_ACT_NONE) |=> (pin_out == compare_output);
	endproperty
	a_pin_src: assert property (p_pin_src) else $error("Pin not driven by output.");

	property p_force_set;
		@(posedge clk) disable iff (reset)
		(force_ev && output_action_select == TCC_ACT_SET) |=> compare_output;
	endproperty
	a_force_set: assert property (p_force_set) else $error("Force set failed.");

endmodule

// ===== verilog/tcc_timer.sv
// Top of the 8-bit timer counter with one compare unit.
// ****************************************
// How it works
// ****************************************
// How it works
// - Per mode the counter clears, counts up or down once per tick only.
// - Clock source zero stops ticks; counter stays readable and writable.
// - A counter write beats any clear or count in the same cycle.
// - Counter equal to compare value sets the compare flag at the next tick.
// - Compare interrupt needs flag, compare enable and global enable.
// - Compare flag clears on service or on a write of one.
// - PWM modes buffer the compare value; other modes write it directly.
// - The buffer loads into the active compare value at top (0xff) only.
// - Compare reads and writes go to the buffer or the active value.
// - Force strobe in non-PWM modes acts as a match, without flag or clear.
// - A counter write blocks compare matches in the next tick, even stopped.
// - A new output action applies from the first match after the write.
// - Reset clears the compare output; mode changes keep it.
// - Nonzero output action takes over pin data; direction stays separate.
// - Output action zero leaves the compare output unchanged on a match.
// - The counting sequence depends on the waveform mode, and in clear-on-match mode on the compare value.
// - Normal mode counts up only and wraps from 0xff to 0x00.
// - Normal mode sets the overflow flag as the counter becomes zero.
// - Servicing the overflow interrupt clears the overflow flag.
// - Clear-on-match mode clears the counter on the tick after a match.
// - Clear-on-match mode sets the overflow flag on a wrap from 0xff.
// - Output action one toggles the output on each match in clear-on-match mode.
module tcc_timer
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Configuration.
	input wire tcc_pkg::tcc_ctrl_t ctrl,
	input wire tcc_pkg::tcc_irq_en_t irq_en,
	input wire logic ext_event,
	// Counter access.
	input wire logic counter_wr,
	input wire logic [7:0] counter_wdata,
	output logic [7:0] counter_value,
	// Compare value access.
	input wire logic compare_wr,
	input wire logic [7:0] compare_wdata,
	output logic [7:0] compare_value,
	input wire logic force_compare_strobe,
	// Flags and interrupts.
	input wire logic compare_flag_w1c,
	input wire logic overflow_flag_w1c,
	input wire logic compare_irq_ack,
	input wire logic overflow_irq_ack,
	output logic compare_flag,
	output logic overflow_flag,
	output logic compare_irq,
	output logic overflow_irq,
	// Port pin.
	input wire logic port_data,
	input wire logic pin_direction_bit,
	output logic compare_output,
	output logic pin_out,
	output logic pin_oe_n
);
	import tcc_pkg::*;

	// ****************************************
	// Internal signals
	// ****************************************
	logic timer_tick;
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic up_q;
	logic block_q;
	logic [7:0] act_q;
	logic [7:0] buf_q;
	logic pwm;
	logic match_raw;
	logic match_hit;
	logic at_max;
	logic load_ev;
	logic ovf_ev;
	logic bottom_ev;
	logic force_ev;
	logic [1:0] mode;

	assign mode = ctrl.waveform_mode_select;
	assign pwm = (mode == TCC_WGM_PCPWM) || (mode == TCC_WGM_FAST);
	assign at_max = count_q == TCC_MAX;
	assign match_raw = count_q == act_q;
	assign match_hit = timer_tick && match_raw && !block_q;
	assign force_ev = force_compare_strobe && !pwm;
	assign bottom_ev = timer_tick && !counter_wr && at_max && mode == TCC_WGM_FAST;
	assign load_ev = timer_tick && at_max;

	// ****************************************
	// Tick generator
	// ****************************************
	tcc_tick_gen u_tick
	(
		.clk(clk),
		.reset(reset),
		.clock_source_select(ctrl.clock_source_select),
		.ext_event(ext_event),
		.timer_tick(timer_tick)
	);

	// ****************************************
	// Counter
	// ****************************************
	always_comb
	begin
		count_d = count_q;
		if (timer_tick)
		begin
			unique case (mode)
				TCC_WGM_NORMAL: count_d = count_q + TCC_ONE;
				TCC_WGM_CLR_MATCH: count_d = (match_raw && !block_q) ? TCC_BOTTOM : count_q + TCC_ONE;
				TCC_WGM_FAST: count_d = count_q + TCC_ONE;
				TCC_WGM_PCPWM:
					if (up_q)
						count_d = at_max ? count_q - TCC_ONE : count_q + TCC_ONE;
					else
						count_d = (count_q == TCC_BOTTOM) ? count_q + TCC_ONE : count_q - TCC_ONE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			count_q <= TCC_COUNT_RST;
		else if (counter_wr)
			count_q <= counter_wdata;
		else
			count_q <= count_d;
	end

	// Direction only turns in the dual-slope mode.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			up_q <= 1'b1;
		else if (mode != TCC_WGM_PCPWM)
			up_q <= 1'b1;
		else if (timer_tick && !counter_wr && at_max)
			up_q <= 1'b0;
		else if (timer_tick && !counter_wr && count_q == TCC_BOTTOM)
			up_q <= 1'b1;
	end

	// A counter write arms the block until the next tick has passed.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			block_q <= 1'b0;
		else if (counter_wr)
			block_q <= 1'b1;
		else if (timer_tick)
			block_q <= 1'b0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			counter_value <= TCC_COUNT_RST;
		else if (counter_wr)
			counter_value <= counter_wdata;
		else
			counter_value <= count_d;
	end

	// ****************************************
	// Compare value
	// ****************************************
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			buf_q <= TCC_CMP_RST;
		else if (compare_wr)
			buf_q <= compare_wdata;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			act_q <= TCC_CMP_RST;
		else if (compare_wr && !pwm)
			act_q <= compare_wdata;
		else if (pwm && load_ev)
			act_q <= buf_q;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			compare_value <= TCC_CMP_RST;
		else
			compare_value <= pwm ? buf_q : act_q;
	end

	// ****************************************
	// Flags and interrupts
	// ****************************************
	always_comb
	begin
		if (mode == TCC_WGM_PCPWM)
			ovf_ev = timer_tick && !counter_wr && !up_q && count_q == TCC_ONE;
		else
			ovf_ev = timer_tick && !counter_wr && at_max;
	end

	// A set in the same cycle as a clear wins.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			compare_flag <= 1'b0;
		else if (match_hit)
			compare_flag <= 1'b1;
		else if (compare_irq_ack || compare_flag_w1c)
			compare_flag <= 1'b0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			overflow_flag <= 1'b0;
		else if (ovf_ev)
			overflow_flag <= 1'b1;
		else if (overflow_irq_ack || overflow_flag_w1c)
			overflow_flag <= 1'b0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			compare_irq <= 1'b0;
			overflow_irq <= 1'b0;
		end
		else
		begin
			compare_irq <= compare_flag && irq_en.compare_irq_enable && irq_en.global_irq_enable;
			overflow_irq <= overflow_flag && irq_en.overflow_irq_enable && irq_en.global_irq_enable;
		end
	end

	// ****************************************
	// Compare output
	// ****************************************
	tcc_out_unit u_out
	(
		.clk(clk),
		.reset(reset),
		.waveform_mode_select(mode),
		.output_action_select(ctrl.output_action_select),
		.match_ev(match_hit),
		.force_ev(force_ev),
		.bottom_ev(bottom_ev),
		.count_up(up_q),
		.port_data(port_data),
		.pin_direction_bit(pin_direction_bit),
		.compare_output(compare_output),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_wr_then_tick;
		counter_wr ##1 (timer_tick && !counter_wr);
	endsequence

	property p_idle_hold;
		(!timer_tick && !counter_wr) |=> $stable(counter_value);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("Counter moved between ticks.");

	property p_stop;
		(ctrl.clock_source_select == TCC_CS_STOP) |=> !timer_tick;
	endproperty
	a_stop: assert property (p_stop) else $error("Tick while stopped.");

	property p_wr_wins;
		counter_wr |=> (counter_value == $past(counter_wdata));
	endproperty
	a_wr_wins: assert property (p_wr_wins) else $error("Counter write lost.");

	property p_flag_cause;
		$rose(compare_flag) |-> $past(timer_tick && count_q == act_q && !block_q);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("Compare flag without match.");

	property p_irq;
		compare_irq |-> $past(compare_flag && irq_en.compare_irq_enable && irq_en.global_irq_enable);
	endproperty
	a_irq: assert property (p_irq) else $error("Compare interrupt not gated.");

	property p_flag_clear;
		(compare_flag && compare_flag_w1c && !match_hit) |=> !compare_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("Compare flag not cleared.");

	property p_direct;
		(compare_wr && !pwm) |=> (act_q == $past(compare_wdata));
	endproperty
	a_direct: assert property (p_direct) else $error("Direct compare write lost.");

	property p_block;
		s_wr_then_tick |=> !$rose(compare_flag);
	endproperty
	a_block: assert property (p_block) else $error("Match not blocked after write.");

	property p_force_noflag;
		(force_compare_strobe && !timer_tick) |=> !$rose(compare_flag);
	endproperty
	a_force_noflag: assert property (p_force_noflag) else $error("Force set the flag.");

	property p_wrap;
		(mode == TCC_WGM_NORMAL && timer_tick && !counter_wr && at_max)
			|=> (counter_value == TCC_BOTTOM) && overflow_flag;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Normal wrap or overflow wrong.");

	property p_match_clear;
		(mode == TCC_WGM_CLR_MATCH && match_hit && !counter_wr) |=> (counter_value == TCC_BOTTOM);
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("No clear on match.");

	property p_buf_hold;
		(pwm && !load_ev) |=> $stable(act_q);
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("Active compare moved off top.");

	property p_buf_load;
		(pwm && load_ev) |=> (act_q == $past(buf_q));
	endproperty
	a_buf_load: assert property (p_buf_load) else $error("Buffer not loaded at top.");

	property p_ovf_clear;
		(overflow_flag && (overflow_irq_ack || overflow_flag_w1c) && !ovf_ev) |=> !overflow_flag;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("Overflow flag not cleared.");

endmodule

// ===== dv/tcc_pin_load.sv
// Model of the load on the compare pin: a pull-down when the pin is not driven.
module tcc_pin_load
(
	// Pin as driven by the unit.
	input wire logic pin_out,
	input wire logic pin_oe_n,
	// Level seen by the load.
	output logic pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pin_level = pin_oe_n ? 1'b0 : pin_out;
endmodule

// ===== dv/tcc_timer_tb_top.sv
// Self-checking testbench of the 8-bit timer compare unit.
module tcc_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tcc_pkg::*;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk = 1'b0;
	logic reset = 1'b1;
	tcc_ctrl_t ctrl = '0;
	tcc_irq_en_t irq_en = '0;
	logic counter_wr = 1'b0;
	logic [7:0] counter_wdata = 8'h00;
	logic compare_wr = 1'b0;
	logic [7:0] compare_wdata = 8'h00;
	logic force_compare_strobe = 1'b0;
	logic compare_flag_w1c = 1'b0;
	logic overflow_flag_w1c = 1'b0;
	logic compare_irq_ack = 1'b0;
	logic overflow_irq_ack = 1'b0;
	logic port_data = 1'b1;
	logic pin_direction_bit = 1'b0;
	logic [7:0] counter_value;
	logic [7:0] compare_value;
	logic compare_flag;
	logic overflow_flag;
	logic compare_irq;
	logic overflow_irq;
	logic compare_output;
	logic pin_out;
	logic pin_oe_n;
	logic pin_level;
	logic oc;
	int error_cnt = 0;
	int total_checks = 0;

	always #12.5 clk = ~clk;

	tcc_timer DUT (.clk(clk), .reset(reset), .ctrl(ctrl), .irq_en(irq_en), .ext_event(1'b0),
		.counter_wr(counter_wr), .counter_wdata(counter_wdata), .counter_value(counter_value),
		.compare_wr(compare_wr), .compare_wdata(compare_wdata), .compare_value(compare_value),
		.force_compare_strobe(force_compare_strobe), .compare_flag_w1c(compare_flag_w1c),
		.overflow_flag_w1c(overflow_flag_w1c), .compare_irq_ack(compare_irq_ack),
		.overflow_irq_ack(overflow_irq_ack), .compare_flag(compare_flag),
		.overflow_flag(overflow_flag), .compare_irq(compare_irq), .overflow_irq(overflow_irq),
		.port_data(port_data), .pin_direction_bit(pin_direction_bit),
		.compare_output(compare_output), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

	tcc_pin_load load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic results();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic set_ctl(input logic [2:0] cs, input logic [1:0] wgm, input logic [1:0] act);
		ctrl = '{cs, wgm, act};
		cyc(1);
	endtask

	task automatic wr_cnt(input logic [7:0] v);
		counter_wr = 1'b1;
		counter_wdata = v;
		cyc(1);
		counter_wr = 1'b0;
	endtask

	task automatic wr_cmp(input logic [7:0] v);
		compare_wr = 1'b1;
		compare_wdata = v;
		cyc(1);
		compare_wr = 1'b0;
	endtask

	task automatic strobe();
		force_compare_strobe = 1'b1;
		cyc(1);
		force_compare_strobe = 1'b0;
	endtask

	task automatic clr_cmp_flag();
		compare_flag_w1c = 1'b1;
		cyc(1);
		compare_flag_w1c = 1'b0;
	endtask

	task automatic wait_cnt(input logic [7:0] v, input int bound);
		int i;
		for (i = 0; i < bound && counter_value !== v; i++)
			cyc(1);
		if (counter_value !== v)
		begin
			$display("BAD wait for counter value %h", v);
			error_cnt++;
			results();
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_stopped();
		set_ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_ACT_NONE);
		wr_cmp(8'h05);
		wr_cnt(8'h05);
		chk("stopped write", 8'h05, counter_value);
		cyc(10);
		chk("stopped hold", 8'h05, counter_value);
		chk("stopped flag", 1'b0, compare_flag);
	endtask

	task automatic t_priority();
		set_ctl(TCC_CS_DIV1, TCC_WGM_NORMAL, TCC_ACT_NONE);
		cyc(3);
		wr_cnt(8'h40);
		chk("write wins", 8'h40, counter_value);
		cyc(1);
		chk("one per tick", 8'h41, counter_value);
		set_ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_ACT_NONE);
		wr_cnt(8'h05);
	endtask

	task automatic t_force();
		logic [1:0] acts [5] = '{TCC_ACT_CLEAR, TCC_ACT_SET, TCC_ACT_NONE, TCC_ACT_TOGGLE, TCC_ACT_SET};
		logic exps [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++)
		begin
			set_ctl(TCC_CS_STOP, TCC_WGM_NORMAL, acts[i]);
			strobe();
			chk("forced output", exps[i], compare_output);
			chk("forced flag", 1'b0, compare_flag);
			chk("forced counter", 8'h05, counter_value);
		end
		pin_direction_bit = 1'b1;
		cyc(1);
		chk("pin driven", 1'b0, pin_oe_n);
		chk("pin level", 1'b1, pin_level);
		set_ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_ACT_NONE);
		port_data = 1'b0;
		cyc(1);
		chk("port data on pin", 1'b0, pin_out);
		set_ctl(TCC_CS_STOP, TCC_WGM_FAST, TCC_ACT_CLEAR);
		strobe();
		chk("force ignored in pwm", 1'b1, compare_output);
		wr_cmp(8'h80);
		cyc(1);
		chk("buffer read", 8'h80, compare_value);
	endtask

	task automatic t_overflow();
		set_ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_ACT_NONE);
		wr_cmp(8'h10);
		wr_cnt(8'hfe);
		irq_en = '{1'b1, 1'b1, 1'b1};
		chk("overflow idle", 1'b0, overflow_flag);
		set_ctl(TCC_CS_DIV1, TCC_WGM_NORMAL, TCC_ACT_NONE);
		wait_cnt(8'h00, 10);
		chk("overflow at zero", 1'b1, overflow_flag);
		cyc(1);
		chk("count after wrap", 8'h01, counter_value);
		chk("overflow irq", 1'b1, overflow_irq);
		overflow_irq_ack = 1'b1;
		cyc(1);
		overflow_irq_ack = 1'b0;
		chk("overflow serviced", 1'b0, overflow_flag);
	endtask

	task automatic t_match_clear();
		set_ctl(TCC_CS_STOP, TCC_WGM_CLR_MATCH, TCC_ACT_TOGGLE);
		clr_cmp_flag();
		chk("flag write one", 1'b0, compare_flag);
		wr_cmp(8'h03);
		cyc(1);
		chk("direct compare", 8'h03, compare_value);
		wr_cnt(8'h00);
		oc = compare_output;
		set_ctl(TCC_CS_DIV1, TCC_WGM_CLR_MATCH, TCC_ACT_TOGGLE);
		wait_cnt(8'h03, 10);
		cyc(1);
		chk("clear on match", 8'h00, counter_value);
		chk("match flag", 1'b1, compare_flag);
		chk("toggle", !oc, compare_output);
		cyc(1);
		chk("compare irq", 1'b1, compare_irq);
		ctrl.output_action_select = oc ? TCC_ACT_CLEAR : TCC_ACT_SET;
		clr_cmp_flag();
		chk("flag cleared by one", 1'b0, compare_flag);
		wait_cnt(8'h03, 10);
		cyc(1);
		chk("new action", !oc, compare_output);
		chk("match flag again", 1'b1, compare_flag);
		irq_en.global_irq_enable = 1'b0;
		clr_cmp_flag();
		wait_cnt(8'h03, 10);
		cyc(2);
		chk("flag without global", 1'b1, compare_flag);
		chk("irq masked", 1'b0, compare_irq);
		compare_irq_ack = 1'b1;
		cyc(1);
		compare_irq_ack = 1'b0;
		chk("flag serviced", 1'b0, compare_flag);
		wr_cnt(8'h03);
		cyc(1);
		chk("blocked match", 8'h04, counter_value);
		chk("blocked flag", 1'b0, compare_flag);
		set_ctl(TCC_CS_STOP, TCC_WGM_CLR_MATCH, TCC_ACT_NONE);
	endtask

	task automatic t_presc();
		logic [7:0] v;
		set_ctl(TCC_CS_DIV8, TCC_WGM_NORMAL, TCC_ACT_NONE);
		v = counter_value;
		cyc(16);
		chk("divided tick", v + 8'h02, counter_value);
		set_ctl(TCC_CS_STOP, TCC_WGM_NORMAL, TCC_ACT_NONE);
	endtask

	task automatic t_pwm();
		set_ctl(TCC_CS_STOP, TCC_WGM_PCPWM, TCC_ACT_NONE);
		wr_cmp(8'h40);
		wr_cnt(8'h3e);
		chk("buffer only", 8'h40, compare_value);
		set_ctl(TCC_CS_DIV1, TCC_WGM_PCPWM, TCC_ACT_NONE);
		wait_cnt(8'h41, 10);
		chk("no early match", 1'b0, compare_flag);
		wait_cnt(8'hff, 200);
		cyc(1);
		chk("count down after top", 8'hfe, counter_value);
		wait_cnt(8'h3f, 300);
		chk("buffer loaded at top", 1'b1, compare_flag);
		set_ctl(TCC_CS_STOP, TCC_WGM_PCPWM, TCC_ACT_NONE);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		cyc(19);
		chk("reset counter", 8'h00, counter_value);
		chk("reset output", 1'b0, compare_output);
		chk("reset pin enable", 1'b1, pin_oe_n);
		chk("reset flag", 1'b0, compare_flag);
		cyc(1);
		reset = 1'b0;
		cyc(2);
		t_stopped();
		t_priority();
		t_force();
		t_overflow();
		t_match_clear();
		t_presc();
		t_pwm();
		results();
	end
endmodule
